// ===== odc_chk_sva.sv
`timescale 1ns/100ps
// Port-level checker; the blink bound follows BLINK_CYC
module odc_chk import odc_pkg::*; #(parameter int NCH = 6, parameter int BLINK_CYC = 4) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic [2:0] reg_sel,
	input wire logic [15:0] reg_wdata,
	input wire logic web_set,
	input wire logic [2:0] web_ch,
	input wire logic web_release,
	input wire logic [15:0] status_q,
	input wire logic run_led_q,
	input wire logic [NCH*ODC_DAC_W-1:0] dac_q
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// Access and wink key writes
	wire logic acc = reg_wr && reg_sel == ODC_SEL_ACCESS;
	wire logic wnk = reg_wr && reg_sel == ODC_SEL_WINK && reg_wdata == ODC_WINK_KEY;
	// Trigger writes may legally move a held channel through new coefficients
	wire logic cap = reg_wr && (reg_sel == ODC_SEL_ZERO || reg_sel == ODC_SEL_SPAN);
	// Channel last put on hold
	logic [2:0] held_ch_q;
	// Indicator level one cycle back
	logic led_prev_q;
	// Cycles the indicator has stood still while winking
	int still_q;
	// Track the held channel from the set-output pulse
	always_ff @(posedge core_clk) begin
		if (rst) begin
			held_ch_q <= 3'h0;
		end else if (web_set) begin
			held_ch_q <= web_ch;
		end
	end
	// Run length of a steady indicator; cleared outside wink mode
	always_ff @(posedge core_clk) begin
		led_prev_q <= run_led_q;
		if (rst || !status_q[0] || run_led_q != led_prev_q) begin
			still_q <= 0;
		end else begin
			still_q <= still_q + 1;
		end
	end
	a_unlock_seen: assert property (acc && reg_wdata == ODC_UNLOCK_KEY ##1 !acc |-> ##1 status_q[1])
		else $error("unlock");
	a_lock_seen: assert property (acc && reg_wdata == ODC_LOCK_KEY ##1 !acc |-> ##1 !status_q[1])
		else $error("lock");
	a_wink_toggles: assert property (!wnk ##1 wnk ##1 !wnk |-> ##1 status_q[0] != $past(status_q[0], 2))
		else $error("wink");
	a_led_steady: assert property (!status_q[0] [*3] |-> run_led_q)
		else $error("steady");
	a_led_blinks: assert property (still_q <= BLINK_CYC)
		else $error("blink");
	a_hold_seen: assert property (web_set ##1 !web_release |-> ##1 status_q[2])
		else $error("hold");
	a_hold_freed: assert property (web_release && !web_set ##1 !web_set |-> ##1 !status_q[2])
		else $error("free");
	// Output writes to the held channel are refused, so its converter word stands still
	a_held_frozen: assert property ((status_q[2] && !cap && !web_set) [*8] |->
		$stable(dac_q[held_ch_q*ODC_DAC_W +: ODC_DAC_W]))
		else $error("frozen");
	cover property (acc && reg_wdata == ODC_UNLOCK_KEY);
	cover property (status_q[0] && $rose(run_led_q));
	cover property (status_q[2] && web_release);
endmodule
bind odc_top odc_chk #(.NCH(NCH), .BLINK_CYC(BLINK_CYC)) u_chk (.core_clk, .rst, .reg_wr, .reg_sel,
	.reg_wdata, .web_set, .web_ch, .web_release, .status_q, .run_led_q, .dac_q);

// ===== odc_client.sv
`timescale 1ns/100ps
// Network client stand-in; one register write per call
module odc_client (
	input wire logic core_clk,
	output logic reg_wr = 1'b0,
	output logic [2:0] reg_sel = 3'h0,
	output logic [2:0] reg_ch = 3'h0,
	output logic [15:0] reg_wdata = 16'h0000
);
	// Held across the sampling edge; data scrambled once released
	task automatic wr(input logic [2:0] s, input logic [2:0] c, input logic [15:0] d);
		@(posedge core_clk);
		#1;
		reg_wr = 1'b1;
		reg_sel = s;
		reg_ch = c;
		reg_wdata = d;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
endmodule

// ===== odc_pkg.sv
package odc_pkg;
	// Register selects on the write port
	localparam logic [2:0] ODC_SEL_ACCESS = 3'h0;
	localparam logic [2:0] ODC_SEL_ZERO = 3'h1;
	localparam logic [2:0] ODC_SEL_SPAN = 3'h2;
	localparam logic [2:0] ODC_SEL_WINK = 3'h3;
	localparam logic [2:0] ODC_SEL_OUTPUT = 3'h4;
	localparam logic [2:0] ODC_SEL_RANGE = 3'h5;
	// Keys
	localparam logic [15:0] ODC_UNLOCK_KEY = 16'h5E2A;
	localparam logic [15:0] ODC_LOCK_KEY = 16'h0000;
	localparam logic [15:0] ODC_WINK_KEY = 16'h5555;
	// Output word scaling, 0.005 % per count
	localparam int ODC_FULL_SCALE = 20000;
	localparam logic signed [15:0] ODC_IDEAL_ZERO = 16'sh0000;
	localparam logic signed [15:0] ODC_IDEAL_SPAN = 16'sh4E20;
	// Range codes
	localparam logic [1:0] ODC_RANGE_BASE = 2'h0;
	localparam logic [1:0] ODC_RANGE_SUB1 = 2'h1;
	localparam logic [1:0] ODC_RANGE_SUB2 = 2'h2;
	// Sub-range endpoints in base-range counts (current model)
	localparam int ODC_CUR_SUB1_LO = -5000;
	localparam int ODC_CUR_SUB1_HI = 20000;
	localparam int ODC_CUR_SUB2_LO = -5000;
	localparam int ODC_CUR_SUB2_HI = -3750;
	// Sub-range endpoints in base-range counts (voltage model)
	localparam int ODC_VLT_SUB1_HI = 10000;
	localparam int ODC_VLT_SUB2_HI = 2000;
	// Converter width and default coefficients
	localparam int ODC_DAC_W = 12;
	localparam logic [11:0] ODC_ZERO_RST = 12'h000;
	localparam logic [11:0] ODC_SPAN_RST = 12'hFFF;
	// Wink blink half period
	localparam int ODC_CLK_HZ = 100_000_000;
	localparam int ODC_BLINK_MS = 250;
	localparam int ODC_BLINK_CYC = ODC_CLK_HZ / 1000 * ODC_BLINK_MS;
endpackage

// ===== odc_top.sv
`timescale 1ns/100ps
// Operation
// - Key 24106 unlocks calibration trigger registers
// - Writing zero relocks calibration trigger registers
// - Zero trigger bit captures channel raw count
// - Span trigger bit captures full-scale count
// - New coefficients apply immediately, no reset
// - Alternate ranges interpolated from base calibration
// - Web span set-output drives ideal 20000
// - Web hold ignores output writes to the held channel until done
// - Key 5555H toggles wink mode
// - Wink blinks run indicator, else steady
// - Output words signed, 20000 is full scale
module odc_top import odc_pkg::*; #(
	parameter int NCH = 6,
	parameter bit VOLTAGE = 1'b0,
	parameter int BLINK_CYC = ODC_BLINK_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic [2:0] reg_sel,
	input wire logic [2:0] reg_ch,
	input wire logic [15:0] reg_wdata,
	input wire logic web_set,
	input wire logic web_span,
	input wire logic [2:0] web_ch,
	input wire logic web_release,
	output logic [15:0] status_q,
	output logic run_led_q,
	output logic [NCH*ODC_DAC_W-1:0] dac_q
);
	localparam int CW = $clog2(NCH);
	localparam int BW = $clog2(BLINK_CYC + 1);

	// Client words and ranges are kept per channel, and one shared
	// transfer converts the channel at the pointer in each cycle.
	// The converter word of that channel is refreshed on the next edge.
	// Trade-off: one multiplier chain instead of one per channel, at the
	// cost of up to NCH cycles before a new word reaches its converter.
	// Endpoints are raw converter counts, so they survive range changes.
	logic unlock_q; // Calibration write enable
	logic wink_q; // Identification mode
	logic [BW-1:0] blink_cnt_q; // Run indicator timer
	logic signed [15:0] out_q [NCH]; // Client output words
	logic [1:0] range_q [NCH]; // Range per channel
	logic [11:0] zero_q [NCH]; // Low endpoint raw counts
	logic [11:0] span_q [NCH]; // High endpoint raw counts
	logic hold_q; // Web calibration holds a channel
	logic hold_span_q; // Held endpoint is span
	logic [2:0] hold_ch_q; // Held channel
	logic [CW-1:0] ptr_q; // Converter update pointer
	logic [11:0] cnt_d; // Count for channel at pointer
	logic signed [15:0] pct; // Selected output word
	logic [1:0] rng; // Selected range
	logic signed [31:0] lo; // Range low in base counts
	logic signed [31:0] hi; // Range high in base counts
	logic signed [31:0] bp; // Base-range equivalent word
	logic signed [47:0] raw; // Interpolated raw count

	// Protection is set after reset so that no stray trigger write
	// can overwrite the stored endpoints before a client unlocks them.
	// Calibration access key
	always_ff @(posedge core_clk) begin
		if (rst) begin
			unlock_q <= 1'b0;
		end else if (reg_wr && reg_sel == ODC_SEL_ACCESS) begin
			if (reg_wdata == ODC_UNLOCK_KEY) begin
				unlock_q <= 1'b1;
			end else if (reg_wdata == ODC_LOCK_KEY) begin
				unlock_q <= 1'b0;
			end
		end
	end

	// One key both sets and clears the mode, so a client that loses
	// track of the state reads the status word rather than guessing.
	// Wink toggle; any other value is ignored
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wink_q <= 1'b0;
		end else if (reg_wr && reg_sel == ODC_SEL_WINK && reg_wdata == ODC_WINK_KEY) begin
			wink_q <= ~wink_q;
		end
	end

	// Registered copy, so a read sees the state one cycle after a write
	// Status: bit 0 wink, bit 1 calibration unlocked, bit 2 web hold
	always_ff @(posedge core_clk) begin
		if (rst) begin
			status_q <= 16'h0000;
		end else begin
			status_q <= {13'h0000, hold_q, unlock_q, wink_q};
		end
	end

	// The timer is parked at zero outside wink mode, so every blink
	// sequence starts with a full half period of light.
	// Run indicator, steady on unless winking
	always_ff @(posedge core_clk) begin
		if (rst) begin
			blink_cnt_q <= '0;
			run_led_q <= 1'b1;
		end else if (!wink_q) begin
			blink_cnt_q <= '0;
			run_led_q <= 1'b1;
		end else if (blink_cnt_q == BW'(BLINK_CYC - 1)) begin
			blink_cnt_q <= '0;
			run_led_q <= ~run_led_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 1'b1;
		end
	end

	// A new set-output while held moves the hold; a set and a release
	// in one cycle leave the hold in force.
	// Web set-output hold, released by completion or restart
	always_ff @(posedge core_clk) begin
		if (rst) begin
			hold_q <= 1'b0;
			hold_span_q <= 1'b0;
			hold_ch_q <= 3'h0;
		end else if (web_set) begin
			hold_q <= 1'b1;
			hold_span_q <= web_span;
			hold_ch_q <= web_ch;
		end else if (web_release) begin
			hold_q <= 1'b0;
		end
	end

	// Output words and ranges; a held channel ignores client output writes but takes range writes
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < NCH; i++) begin
				out_q[i] <= ODC_IDEAL_ZERO;
				range_q[i] <= ODC_RANGE_BASE;
			end
		end else if (reg_wr && int'(reg_ch) < NCH) begin
			if (reg_sel == ODC_SEL_OUTPUT && !(hold_q && hold_ch_q == reg_ch)) begin
				out_q[reg_ch] <= signed'(reg_wdata);
			end
			if (reg_sel == ODC_SEL_RANGE && reg_wdata[1:0] != 2'h3) begin
				range_q[reg_ch] <= reg_wdata[1:0];
			end
		end
	end

	// Capture takes the count the converter shows right now, which is
	// the trimmed value the client adjusted by hand; a held channel
	// captures its ideal endpoint through the present coefficients.
	// Endpoint capture; several set bits capture several channels
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < NCH; i++) begin
				zero_q[i] <= ODC_ZERO_RST;
				span_q[i] <= ODC_SPAN_RST;
			end
		end else if (reg_wr && unlock_q) begin
			for (int i = 0; i < NCH; i++) begin
				if (reg_sel == ODC_SEL_ZERO && reg_wdata[i]) begin
					zero_q[i] <= dac_q[i*ODC_DAC_W +: ODC_DAC_W];
				end
				if (reg_sel == ODC_SEL_SPAN && reg_wdata[i]) begin
					span_q[i] <= dac_q[i*ODC_DAC_W +: ODC_DAC_W];
				end
			end
		end
	end

	// Transfer for the channel at the pointer; one shared datapath
	always_comb begin
		pct = out_q[ptr_q];
		rng = range_q[ptr_q];
		if (hold_q && hold_ch_q == 3'(ptr_q)) begin
			pct = hold_span_q ? ODC_IDEAL_SPAN : ODC_IDEAL_ZERO;
			rng = ODC_RANGE_BASE;
		end
		// Base range spans the whole calibrated scale
		lo = 0;
		hi = ODC_FULL_SCALE;
		// Sub-range ends expressed on the base scale
		if (rng == ODC_RANGE_SUB1) begin
			lo = VOLTAGE ? 0 : ODC_CUR_SUB1_LO;
			hi = VOLTAGE ? ODC_VLT_SUB1_HI : ODC_CUR_SUB1_HI;
		end else if (rng == ODC_RANGE_SUB2) begin
			lo = VOLTAGE ? 0 : ODC_CUR_SUB2_LO;
			hi = VOLTAGE ? ODC_VLT_SUB2_HI : ODC_CUR_SUB2_HI;
		end
		bp = lo + (32'(pct) * (hi - lo)) / ODC_FULL_SCALE;
		// Coefficients are read live, so a capture applies next pass
		raw = 48'(signed'({1'b0, zero_q[ptr_q]})) + (48'(signed'({1'b0, span_q[ptr_q]}))
			- 48'(signed'({1'b0, zero_q[ptr_q]}))) * 48'(bp) / ODC_FULL_SCALE;
		// Clamp to the converter's span
		if (raw < 0) begin
			cnt_d = 12'h000;
		end else if (raw > 48'sd4095) begin
			cnt_d = 12'hFFF;
		end else begin
			cnt_d = raw[11:0];
		end
	end

	// Converter words are registers, so the converters never see
	// the combinational transfer settling.
	// Round-robin converter refresh
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ptr_q <= '0;
			dac_q <= '0;
		end else begin
			dac_q[ptr_q*ODC_DAC_W +: ODC_DAC_W] <= cnt_d;
			ptr_q <= (ptr_q == CW'(NCH - 1)) ? '0 : ptr_q + 1'b1;
		end
	end
endmodule

// ===== output_dac_calibration_control_tb_top.sv
`timescale 1ns/100ps
module output_dac_calibration_control_tb_top import odc_pkg::*;;
	logic core_clk = 1'b0, rst = 1'b1, web_set = 1'b0, web_span = 1'b1, web_release = 1'b0, reg_wr, run_led_q;
	logic [2:0] web_ch = 3'h3, reg_sel, reg_ch;
	logic [15:0] reg_wdata, status_q, lf = 16'h0058;
	logic [71:0] dac_q, dac_v;
	int n_mismatch = 0, checks_done = 0, cyc = 0, zc, sc, p;
	always #5 core_clk = ~core_clk;
	odc_client u_cli (.core_clk, .reg_wr, .reg_sel, .reg_ch, .reg_wdata);
	odc_top #(.BLINK_CYC(4)) u_dut (.core_clk, .rst, .reg_wr, .reg_sel, .reg_ch, .reg_wdata, .web_set,
		.web_span, .web_ch, .web_release, .status_q, .run_led_q, .dac_q);
	// Voltage model on the same inputs, for the voltage sub-range ends
	odc_top #(.VOLTAGE(1'b1), .BLINK_CYC(4)) u_dut_v (.core_clk, .rst, .reg_wr, .reg_sel, .reg_ch, .reg_wdata,
		.web_set, .web_span, .web_ch, .web_release, .status_q(), .run_led_q(), .dac_q(dac_v));
	// Hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// Range endpoints first, then coefficients, clamped to the converter
	function automatic logic [15:0] ex(input int p, input int r, input int z, input int s, input bit v = 1'b0);
		int lo;
		int hi;
		int c;
		lo = r == 0 || v ? 0 : r == 1 ? ODC_CUR_SUB1_LO : ODC_CUR_SUB2_LO;
		hi = r == 0 ? 20000 : r == 1 ? (v ? ODC_VLT_SUB1_HI : ODC_CUR_SUB1_HI) : (v ? ODC_VLT_SUB2_HI : ODC_CUR_SUB2_HI);
		c = lo + p * (hi - lo) / 20000;
		c = z + (s - z) * c / 20000;
		return 16'(c < 0 ? 0 : c > 4095 ? 4095 : c);
	endfunction
	// Output write, then wait out the refresh sweep
	task automatic ow(input int c, input int v, input logic [15:0] e);
		u_cli.wr(ODC_SEL_OUTPUT, 3'(c), 16'(v));
		repeat (8) @(posedge core_clk);
		#1;
		chk("dac", e, {4'h0, dac_q[c*12+:12]});
	endtask
	task automatic st(input int b, input logic e);
		repeat (2) @(posedge core_clk);
		#1;
		chk("status", {15'h0000, e}, {15'h0000, status_q[b]});
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		#1 rst = 1'b0;
		for (int i = 0; i < 10; i++) begin
			lf = lfsr(lf);
			p = i == 0 ? 32767 : i == 1 ? -32768 : int'($signed(lf));
			ow(int'(lf[2:0]) % 6, p, ex(p, 0, 0, 4095));
		end
		ow(0, 10000, ex(10000, 0, 0, 4095));
		u_cli.wr(ODC_SEL_ZERO, 3'h0, 16'h0001);
		ow(0, 0, 16'h0000);
		zc = ex(4000, 0, 0, 4095);
		sc = ex(16000, 0, zc, 4095);
		u_cli.wr(ODC_SEL_RANGE, 3'h0, 16'h0000);
		u_cli.wr(ODC_SEL_ACCESS, 3'h0, ODC_UNLOCK_KEY);
		st(1, 1'b1);
		ow(0, 4000, 16'(zc));
		u_cli.wr(ODC_SEL_ZERO, 3'h0, 16'h0001);
		ow(0, 16000, 16'(sc));
		u_cli.wr(ODC_SEL_SPAN, 3'h0, 16'h0001);
		u_cli.wr(ODC_SEL_ACCESS, 3'h0, ODC_LOCK_KEY);
		st(1, 1'b0);
		// Code 3 is refused, so range 2 stays in force
		for (int r = 0; r < 4; r++) begin
			u_cli.wr(ODC_SEL_RANGE, 3'h0, 16'(r));
			ow(0, 16000, ex(16000, r > 2 ? 2 : r, zc, sc));
			chk("dac_v", ex(16000, r > 2 ? 2 : r, zc, sc, 1'b1), {4'h0, dac_v[11:0]});
		end
		for (int k = 0; k < 3; k++) begin
			u_cli.wr(ODC_SEL_WINK, 3'h0, k == 1 ? 16'h5554 : ODC_WINK_KEY);
			repeat (12) @(posedge core_clk);
			#1;
			chk("wink", {15'h0000, k != 2}, {15'h0000, status_q[0]});
		end
		chk("led", 16'h0001, {15'h0000, run_led_q});
		web_set = 1'b1;
		@(posedge core_clk);
		#1 web_set = 1'b0;
		st(2, 1'b1);
		ow(3, 0, ex(20000, 0, 0, 4095));
		web_release = 1'b1;
		@(posedge core_clk);
		#1 web_release = 1'b0;
		st(2, 1'b0);
		ow(3, 0, 16'h0000);
		// Zero set-output on another channel; its own word must survive the hold
		ow(1, 6000, ex(6000, 0, 0, 4095));
		web_ch = 3'h1;
		web_span = 1'b0;
		web_set = 1'b1;
		@(posedge core_clk);
		#1 web_set = 1'b0;
		ow(1, 20000, ex(0, 0, 0, 4095));
		web_release = 1'b1;
		@(posedge core_clk);
		#1 web_release = 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
		chk("dac", ex(6000, 0, 0, 4095), {4'h0, dac_q[23:12]});
		complete_run();
	end
endmodule
